// ==== verilog/lbm_ctrl.sv ====
// Bar meter and ghost discharge controller with AXI4-Lite registers
`timescale 1ns/1ps
`include "lbm_regs.svh"
// Contract
// - Any group enable overrides per-LED music sync
// - Four single-column group enables
// - Single column lights rows bottom up, odd thresholds
// - Two column-pair group enables
// - Pair: odd columns first, then even
// - One whole-matrix group enable
// - Whole matrix adds two LEDs per step
// - Ghost discharge enable bit
// - Discharge low while disabled
// - Discharge two clocks inside four-clock dead time
// - Cathodes at half supply while discharging
// - Auto threshold steps eight levels upward
// - Music sync defaults to auto threshold
module lbm_ctrl #(
   parameter int STEP_CLKS = `LBM_STEP_CLKS   // Scan step length in clocks
) (
   input  wire logic        CLK,            // 50 MHz clock
   input  wire logic        RST_B,          // Async reset, active low
   input  wire logic [7:0]  S_AXI_AWADDR,   // Write address
   input  wire logic        S_AXI_AWVALID,  // Write address valid
   output logic             S_AXI_AWREADY,  // Write address ready
   input  wire logic [31:0] S_AXI_WDATA,    // Write data
   input  wire logic [3:0]  S_AXI_WSTRB,    // Write strobes
   input  wire logic        S_AXI_WVALID,   // Write data valid
   output logic             S_AXI_WREADY,   // Write data ready
   output logic [1:0]       S_AXI_BRESP,    // Write response
   output logic             S_AXI_BVALID,   // Write response valid
   input  wire logic        S_AXI_BREADY,   // Write response ready
   input  wire logic [7:0]  S_AXI_ARADDR,   // Read address
   input  wire logic        S_AXI_ARVALID,  // Read address valid
   output logic             S_AXI_ARREADY,  // Read address ready
   output logic [31:0]      S_AXI_RDATA,    // Read data
   output logic [1:0]       S_AXI_RRESP,    // Read response
   output logic             S_AXI_RVALID,   // Read data valid
   input  wire logic        S_AXI_RREADY,   // Read data ready
   input  wire logic [15:0] MELODY_LED_ON,  // Per-LED music sync map
   input  wire logic [15:0] OTHER_LED_ON,   // Map from other LED modes
   output logic [15:0]      LED_ON,         // Final LED on map
   output logic [2:0]       THR_LEVEL,      // Threshold level minus one
   output logic             AUTO_THR,       // Auto threshold active
   output logic [1:0]       ROW_SCAN_STEP,  // Active scan row
   output logic             SCAN_DEAD,      // Dead time between scan steps
   output logic             GHOST_DISCHARGE,// Ghost discharge control
   output logic             CATHODE_HALF    // Cathodes forced to half supply
);
   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************
   logic rst_meta_ff;   // First stage
   logic rst_sync_ff;   // Synchronised reset, active low
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   wire rst_n = rst_sync_ff;   // Design reset, active low

   // ****************************************************************
   // Register bus
   // ****************************************************************
   logic [31:0] mode_ff,  nxt_mode;     // Mode register
   logic [31:0] group_ff, nxt_group;    // Group enables
   logic [31:0] thr_ff,   nxt_thr;      // Fixed threshold select
   logic        aw_ff, nxt_aw;          // Write address held
   logic        w_ff,  nxt_w;           // Write data held
   logic [7:0]  awa_ff, nxt_awa;        // Held write address
   logic [31:0] wd_ff, nxt_wd;          // Held write data
   logic [3:0]  ws_ff, nxt_ws;          // Held strobes
   logic        bv_ff, nxt_bv;          // Write response valid
   logic [1:0]  br_ff, nxt_br;          // Write response code
   logic        rv_ff, nxt_rv;          // Read valid
   logic [31:0] rd_ff, nxt_rd;          // Read data
   logic [1:0]  rr_ff, nxt_rr;          // Read response code
   logic [2:0]  lvl_ff, nxt_lvl;        // Threshold level
   logic        bar_act;                // Any group enabled

   // Byte lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++)
         merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
   endfunction

   // Address decode: is the offset mapped
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `LBM_MODE_OFFS) || (a == `LBM_GROUP_OFFS) ||
               (a == `LBM_THR_OFFS) || (a == `LBM_STATUS_OFFS);
   endfunction

   assign S_AXI_AWREADY = !aw_ff && !bv_ff;
   assign S_AXI_WREADY  = !w_ff && !bv_ff;
   assign S_AXI_ARREADY = !rv_ff;
   assign S_AXI_BVALID  = bv_ff;
   assign S_AXI_BRESP   = br_ff;
   assign S_AXI_RVALID  = rv_ff;
   assign S_AXI_RDATA   = rd_ff;
   assign S_AXI_RRESP   = rr_ff;

   // Next state of the bus slave and registers
   always_comb begin
      logic        do_wr;
      logic [7:0]  wa;
      logic [31:0] wdat;
      logic [3:0]  wbe;
      do_wr     = 1'b0;
      wa        = awa_ff;
      wdat      = wd_ff;
      wbe       = ws_ff;
      nxt_mode  = mode_ff;
      nxt_group = group_ff;
      nxt_thr   = thr_ff;
      nxt_aw    = aw_ff;
      nxt_w     = w_ff;
      nxt_awa   = awa_ff;
      nxt_wd    = wd_ff;
      nxt_ws    = ws_ff;
      nxt_bv    = bv_ff;
      nxt_br    = br_ff;
      nxt_rv    = rv_ff;
      nxt_rd    = rd_ff;
      nxt_rr    = rr_ff;
      // Capture address and data in either order
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         nxt_aw  = 1'b1;
         nxt_awa = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         nxt_w  = 1'b1;
         nxt_wd = S_AXI_WDATA;
         nxt_ws = S_AXI_WSTRB;
      end
      wa   = nxt_awa;
      wdat = nxt_wd;
      wbe  = nxt_ws;
      if (nxt_aw && nxt_w && !bv_ff) begin
         do_wr  = 1'b1;
         nxt_aw = 1'b0;
         nxt_w  = 1'b0;
         nxt_bv = 1'b1;
         nxt_br = mapped(wa) ? 2'b00 : 2'b10;
      end
      if (bv_ff && S_AXI_BREADY)
         nxt_bv = 1'b0;
      // Register writes
      if (do_wr) begin
         case (wa)
            `LBM_MODE_OFFS:  nxt_mode  = merge(mode_ff, wdat, wbe);
            `LBM_GROUP_OFFS: nxt_group = merge(group_ff, wdat, wbe);
            `LBM_THR_OFFS:   nxt_thr   = merge(thr_ff, wdat, wbe);
            default:         nxt_thr   = thr_ff;
         endcase
      end
      // Reads
      if (rv_ff && S_AXI_RREADY)
         nxt_rv = 1'b0;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         nxt_rv = 1'b1;
         nxt_rr = mapped(S_AXI_ARADDR) ? 2'b00 : 2'b10;
         case (S_AXI_ARADDR)
            `LBM_MODE_OFFS:   nxt_rd = {28'h0, mode_ff[3:2], 2'h0};
            `LBM_GROUP_OFFS:  nxt_rd = {25'h0, group_ff[6:0]};
            `LBM_THR_OFFS:    nxt_rd = {24'h0, thr_ff[7:0]};
            `LBM_STATUS_OFFS: nxt_rd = {26'h0, GHOST_DISCHARGE, bar_act, AUTO_THR, lvl_ff};
            default:          nxt_rd = 32'h0;
         endcase
      end
   end

   // Register bank flip-flops
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff  <= `LBM_MODE_RESET;
         group_ff <= `LBM_GROUP_RESET;
         thr_ff   <= `LBM_THR_RESET;
         aw_ff    <= 1'b0;
         w_ff     <= 1'b0;
         awa_ff   <= 8'h00;
         wd_ff    <= 32'h0;
         ws_ff    <= 4'h0;
         bv_ff    <= 1'b0;
         br_ff    <= 2'h0;
         rv_ff    <= 1'b0;
         rd_ff    <= 32'h0;
         rr_ff    <= 2'h0;
      end else begin
         mode_ff  <= nxt_mode;
         group_ff <= nxt_group;
         thr_ff   <= nxt_thr;
         aw_ff    <= nxt_aw;
         w_ff     <= nxt_w;
         awa_ff   <= nxt_awa;
         wd_ff    <= nxt_wd;
         ws_ff    <= nxt_ws;
         bv_ff    <= nxt_bv;
         br_ff    <= nxt_br;
         rv_ff    <= nxt_rv;
         rd_ff    <= nxt_rd;
         rr_ff    <= nxt_rr;
      end
   end

   // ****************************************************************
   // Field decode
   // ****************************************************************
   wire       ghost_discharge_en    = mode_ff[`LBM_MODE_GHOST_BIT];
   wire       music_sync_en         = mode_ff[`LBM_MODE_MUSIC_BIT];
   wire [3:0] col_group_en          = group_ff[`LBM_GRP_COL_LSB +: 4];
   wire [1:0] pair_group_en         = group_ff[`LBM_GRP_PAIR_LSB +: 2];
   wire       whole_matrix_group_en = group_ff[`LBM_WHOLE_MATRIX_GROUP_EN_BIT];
   wire [7:0] threshold_select      = thr_ff[7:0];
   assign bar_act = |{col_group_en, pair_group_en, whole_matrix_group_en};

   // ****************************************************************
   // Threshold sequencer
   // ****************************************************************
   localparam int THR_CYC = (`LBM_THR_STEP_NS + `LBM_CLK_NS - 1) / `LBM_CLK_NS;
   logic [7:0] tdiv_ff, nxt_tdiv;   // Step prescaler
   logic [2:0] fixed_lvl;           // Lowest set fixed bit

   // Auto sweep or fixed pick
   always_comb begin
      fixed_lvl = 3'h0;
      for (int i = 7; i >= 0; i--)
         if (threshold_select[i])
            fixed_lvl = 3'(i);
      AUTO_THR = music_sync_en && (threshold_select == 8'h00);
      nxt_tdiv = tdiv_ff;
      nxt_lvl  = lvl_ff;
      if (!AUTO_THR) begin
         nxt_tdiv = 8'h00;
         nxt_lvl  = fixed_lvl;
      end else if (tdiv_ff == 8'(THR_CYC - 1)) begin
         nxt_tdiv = 8'h00;
         nxt_lvl  = lvl_ff + 3'h1;
      end else begin
         nxt_tdiv = tdiv_ff + 8'h01;
      end
   end

   // Sequencer flip-flops
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         tdiv_ff <= 8'h00;
         lvl_ff  <= 3'h0;
      end else begin
         tdiv_ff <= nxt_tdiv;
         lvl_ff  <= nxt_lvl;
      end
   end
   assign THR_LEVEL = lvl_ff;

   // ****************************************************************
   // Bar meter mapping
   // ****************************************************************
   lbm_pkg::lbm_led_t bar_on;    // Bar meter LED map
   lbm_pkg::lbm_led_t bar_own;   // Bar meter owned LEDs
   logic [15:0]       led_ff, nxt_led;

   lbm_pattern u_pattern (
      .level   (lvl_ff),
      .col_en  (col_group_en),
      .pair_en (pair_group_en),
      .all_en  (whole_matrix_group_en),
      .led_on  (bar_on),
      .led_own (bar_own)
   );

   // Merge bar meter with melody and other modes
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (bar_own[i])
            nxt_led[i] = bar_on[i];
         else if (bar_act)
            nxt_led[i] = OTHER_LED_ON[i];
         else
            nxt_led[i] = (music_sync_en & MELODY_LED_ON[i]) | OTHER_LED_ON[i];
      end
   end

   // ****************************************************************
   // Row scan and ghost discharge
   // ****************************************************************
   lbm_pkg::lbm_scan_e st_ff, nxt_st;   // Scan state
   logic [7:0]         cnt_ff, nxt_cnt; // Cycle counter in state
   logic [1:0]         row_ff, nxt_row; // Active row
   logic               dis_ff, nxt_dis; // Discharge output

   // Scan: step, dead clock, two discharge clocks, dead clock
   always_comb begin
      nxt_st  = st_ff;
      nxt_cnt = cnt_ff + 8'h01;
      nxt_row = row_ff;
      case (st_ff)
         lbm_pkg::LBM_SCAN: begin
            if (cnt_ff == 8'(STEP_CLKS - 1)) begin
               nxt_st  = lbm_pkg::LBM_DEAD_A;
               nxt_cnt = 8'h00;
            end
         end
         lbm_pkg::LBM_DEAD_A: begin
            nxt_st  = lbm_pkg::LBM_DISCH;
            nxt_cnt = 8'h00;
         end
         lbm_pkg::LBM_DISCH: begin
            if (cnt_ff == 8'(`LBM_DISCH_CLKS - 1)) begin
               nxt_st  = lbm_pkg::LBM_DEAD_B;
               nxt_cnt = 8'h00;
            end
         end
         lbm_pkg::LBM_DEAD_B: begin
            nxt_st  = lbm_pkg::LBM_SCAN;
            nxt_cnt = 8'h00;
            nxt_row = row_ff + 2'h1;
         end
         default: begin
            nxt_st  = lbm_pkg::LBM_SCAN;
            nxt_cnt = 8'h00;
         end
      endcase
      nxt_dis = ghost_discharge_en && (nxt_st == lbm_pkg::LBM_DISCH);
   end

   // Scan flip-flops
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_ff  <= lbm_pkg::LBM_SCAN;
         cnt_ff <= 8'h00;
         row_ff <= 2'h0;
         dis_ff <= 1'b0;
         led_ff <= 16'h0;
      end else begin
         st_ff  <= nxt_st;
         cnt_ff <= nxt_cnt;
         row_ff <= nxt_row;
         dis_ff <= nxt_dis;
         led_ff <= nxt_led;
      end
   end

   assign LED_ON          = led_ff;
   assign ROW_SCAN_STEP   = row_ff;
   assign SCAN_DEAD       = (st_ff != lbm_pkg::LBM_SCAN);
   assign GHOST_DISCHARGE = dis_ff;
   assign CATHODE_HALF    = dis_ff;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   property p_dis_off;
      @(posedge CLK) disable iff (!rst_n) !ghost_discharge_en |=> !GHOST_DISCHARGE;
   endproperty
   a_dis_off: assert property (p_dis_off) else $error("Discharge while disabled");

   property p_dis_two;
      @(posedge CLK) disable iff (!rst_n)
         ($rose(GHOST_DISCHARGE) && ghost_discharge_en && $past(ghost_discharge_en))
         |-> SCAN_DEAD ##1 (GHOST_DISCHARGE && SCAN_DEAD) ##1 (!GHOST_DISCHARGE && SCAN_DEAD);
   endproperty
   a_dis_two: assert property (p_dis_two) else $error("Discharge not two dead clocks");

   property p_dead_len;
      @(posedge CLK) disable iff (!rst_n) $rose(SCAN_DEAD) |-> SCAN_DEAD [*4] ##1 !SCAN_DEAD;
   endproperty
   a_dead_len: assert property (p_dead_len) else $error("Dead time not four clocks");

   property p_half;
      @(posedge CLK) disable iff (!rst_n)
         CATHODE_HALF == ((st_ff == lbm_pkg::LBM_DISCH) && $past(ghost_discharge_en));
   endproperty
   a_half: assert property (p_half) else $error("Cathode level not tied to discharge");

   property p_bar_prio;
      @(posedge CLK) disable iff (!rst_n)
         (whole_matrix_group_en && lvl_ff == 3'h0 && $stable(group_ff)) |=> (LED_ON[3:0] == 4'hc);
   endproperty
   a_bar_prio: assert property (p_bar_prio) else $error("Whole matrix level one wrong");

   property p_sweep;
      @(posedge CLK) disable iff (!rst_n)
         (AUTO_THR && tdiv_ff == 8'(THR_CYC - 1) && $stable(mode_ff) && $stable(thr_ff))
         |=> (THR_LEVEL == $past(THR_LEVEL) + 3'h1);
   endproperty
   a_sweep: assert property (p_sweep) else $error("Auto threshold did not step");

   property p_auto_def;
      @(posedge CLK) disable iff (!rst_n)
         (music_sync_en && threshold_select == 8'h00 && tdiv_ff != 8'(THR_CYC - 1))
         |=> (tdiv_ff == $past(tdiv_ff) + 8'h01);
   endproperty
   a_auto_def: assert property (p_auto_def) else $error("Auto threshold not default");

   property p_col_even;
      @(posedge CLK) disable iff (!rst_n)
         (col_group_en[0] && !pair_group_en[0] && !whole_matrix_group_en && lvl_ff == 3'h1
          && $stable(group_ff)) |=> (LED_ON[3:0] == 4'h8);
   endproperty
   a_col_even: assert property (p_col_even) else $error("Threshold two column pattern");

   property p_own;
      @(posedge CLK) disable iff (!rst_n)
         (bar_act && !bar_own[15] && $stable(group_ff) && $stable(OTHER_LED_ON))
         |=> (LED_ON[15] == $past(OTHER_LED_ON[15]));
   endproperty
   a_own: assert property (p_own) else $error("Ungrouped LED altered");
endmodule // lbm_ctrl

// ==== verilog/lbm_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the bar meter block
`ifndef LBM_REGS_SVH
`define LBM_REGS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
// Word indices; the byte offset on the bus is four times the index
`define LBM_MODE_IDX      8'h04
`define LBM_GROUP_IDX     8'h0a
`define LBM_THR_IDX       8'h0c
`define LBM_STATUS_IDX    8'h0d
`define LBM_MODE_OFFS     (`LBM_MODE_IDX << 2)
`define LBM_GROUP_OFFS    (`LBM_GROUP_IDX << 2)
`define LBM_THR_OFFS      (`LBM_THR_IDX << 2)
`define LBM_STATUS_OFFS   (`LBM_STATUS_IDX << 2)
// ****************************************************************
// Mode register fields
// ****************************************************************
`define LBM_MODE_GHOST_BIT   2
`define LBM_MODE_MUSIC_BIT   3
`define LBM_MODE_RESET       32'h0000_0000
// ****************************************************************
// Group register fields
// ****************************************************************
`define LBM_GRP_COL_LSB      0
`define LBM_GRP_PAIR_LSB     4
`define LBM_WHOLE_MATRIX_GROUP_EN_BIT      6
`define LBM_GROUP_RESET      32'h0000_0000
`define LBM_THR_RESET        32'h0000_0000
// ****************************************************************
// Timing
// ****************************************************************
`define LBM_DEAD_CLKS        4
`define LBM_DISCH_CLKS       2
`define LBM_STEP_CLKS        16
`define LBM_THR_STEP_NS      1000
`define LBM_CLK_NS           20
`endif

// ==== verilog/lbm_pkg.sv ====
// Types shared by the bar meter block
package lbm_pkg;
   // Row scan sequencer states, Gray coded along the usual path
   typedef enum logic [1:0] {
      LBM_SCAN   = 2'b00,
      LBM_DEAD_A = 2'b01,
      LBM_DISCH  = 2'b11,
      LBM_DEAD_B = 2'b10
   } lbm_scan_e;
   typedef logic [15:0] lbm_led_t;
endpackage

// ==== verilog/lbm_pattern.sv ====
// Bar meter pattern generator: LED map from threshold level and group enables
`timescale 1ns/1ps
`include "lbm_regs.svh"
module lbm_pattern (
   input  wire logic [2:0]      level,     // Threshold level minus one
   input  wire logic [3:0]      col_en,    // Single-column group enables
   input  wire logic [1:0]      pair_en,   // Column-pair group enables
   input  wire logic            all_en,    // Whole-matrix group enable
   output lbm_pkg::lbm_led_t    led_on,    // LED on map, bit 4*col+row (row 0 = A)
   output lbm_pkg::lbm_led_t    led_own    // LEDs owned by the bar meter
);
   // Rows lit in a column, bottom up, for a count of 0..4
   function automatic logic [3:0] rows_up(input logic [2:0] n);
      case (n)
         3'h0:    rows_up = 4'h0;
         3'h1:    rows_up = 4'h8;
         3'h2:    rows_up = 4'hc;
         3'h3:    rows_up = 4'he;
         default: rows_up = 4'hf;
      endcase
   endfunction

   logic [3:0] single_col;   // Single column rows
   logic [3:0] pair_a;       // Columns 1 and 3 rows
   logic [3:0] pair_b;       // Columns 2 and 4 rows
   logic [3:0] lvl;          // Threshold 1..8

   // Combinational pattern build
   always_comb begin
      lvl        = {1'b0, level} + 4'h1;
      single_col = rows_up(3'(level[2:1] + 2'h0) + 3'h1);
      pair_a     = rows_up(lvl > 4'h4 ? 3'h4 : lvl[2:0]);
      pair_b     = rows_up(lvl > 4'h4 ? 3'(lvl - 4'h4) : 3'h0);
      led_on     = '0;
      led_own    = '0;
      for (int c = 0; c < 4; c++) begin
         if (col_en[c]) begin
            led_on[4*c +: 4]  = single_col;
            led_own[4*c +: 4] = 4'hf;
         end
         if (pair_en[c/2]) begin
            led_on[4*c +: 4]  = (c % 2 == 0) ? pair_a : pair_b;
            led_own[4*c +: 4] = 4'hf;
         end
         if (all_en) begin
            if (lvl > 4'(2*c + 1))
               led_on[4*c +: 4] = 4'hf;
            else if (lvl == 4'(2*c + 1))
               led_on[4*c +: 4] = 4'hc;
            else
               led_on[4*c +: 4] = 4'h0;
            led_own[4*c +: 4] = 4'hf;
         end
      end
   end
endmodule // lbm_pattern

// ==== verif/lbm_matrix_model.sv ====
// Model of the matrix side: music map and other-mode map
`timescale 1ns/1ps
module lbm_matrix_model (
   input  wire logic   clk,       // Scan clock
   input  wire logic   rst_b,     // Reset, active low
   output logic [15:0] melody_on, // Per-LED music map
   output logic [15:0] other_on   // Other-mode map
);
   logic [31:0] lfsr_ff; // Pattern source
   logic [2:0]  hold_ff; // Clocks on current map
   // ****************************************
   // New random map every eight clocks
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_ff <= 32'hffc6fad8;
         hold_ff <= 3'h0;
      end else begin
         hold_ff <= hold_ff + 3'h1;
         if (hold_ff == 3'h7) lfsr_ff <= {lfsr_ff[30:0], lfsr_ff[31] ^ lfsr_ff[21] ^ lfsr_ff[1] ^ lfsr_ff[0]};
      end
   end
   // Other modes mirror music map, so ungrouped LEDs have one value
   assign melody_on = lfsr_ff[15:0];
   assign other_on  = lfsr_ff[15:0];
endmodule // lbm_matrix_model

// ==== verif/tb.sv ====
// Self-checking bench for the bar meter and ghost discharge block
`timescale 1ns/1ps
`include "lbm_regs.svh"
module tb;
   logic        CLK, RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY; // Inputs
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID; // Handshakes
   logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;     // Addresses
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd, seed; // Data, read value, random state
   logic [3:0]  S_AXI_WSTRB;                    // Byte lanes
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, ROW_SCAN_STEP, p_row; // Responses, scan row now and one clock back
   logic [15:0] MELODY_LED_ON, OTHER_LED_ON, LED_ON, p_map; // LED maps
   logic [2:0]  THR_LEVEL, p_lvl;               // Level now and one clock back
   logic        AUTO_THR, SCAN_DEAD, GHOST_DISCHARGE, CATHODE_HALF, p_dead; // Status
   logic        mon_on, pat_on, win_ok, gh_exp; // Monitor controls
   logic [6:0]  grp;                            // Group enables in force
   logic [6:0]  cfg [8] = '{7'h0f, 7'h05, 7'h0a, 7'h10, 7'h20, 7'h30, 7'h40, 7'h7f}; // Corner configs
   int          bad_count, n_tests, cyc, dead_n, dis_n; // Counters
   lbm_ctrl #(.STEP_CLKS(4)) dut (.CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
      .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .MELODY_LED_ON,
      .OTHER_LED_ON, .LED_ON, .THR_LEVEL, .AUTO_THR, .ROW_SCAN_STEP, .SCAN_DEAD, .GHOST_DISCHARGE, .CATHODE_HALF);
   lbm_matrix_model pm (.clk(CLK), .rst_b(RST_B), .melody_on(MELODY_LED_ON), .other_on(OTHER_LED_ON));
   // ****************************************
   // Clock, 20 ns period
   // ****************************************
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected map: whole over pair over single column, else music map
   function automatic logic [15:0] bar_exp(input logic [2:0] lv, input logic [6:0] g, input logic [15:0] base);
      logic [15:0] m;
      int l;
      m = base;
      l = lv;
      for (int c = 0; c < 4; c++) begin
         if (g[6]) m[4*c +: 4] = (c < (l+1)/2) ? 4'hf : (c == (l+1)/2 && l%2 == 0) ? 4'hc : 4'h0;
         else if (g[4+c/2]) m[4*c +: 4] = (c%2 == 0) ? ((l < 4) ? 4'hf << (3-l) : 4'hf) : ((l < 4) ? 4'h0 : 4'hf << (7-l));
         else if (g[c]) m[4*c +: 4] = 4'hf << (3 - l/2);
      end
      return m;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      while (!(aw && w)) begin
         @(posedge CLK);
         if (!aw && S_AXI_AWREADY === 1'b1) begin
            aw = 1'b1;
            S_AXI_AWVALID <= 1'b0;
         end
         if (!w && S_AXI_WREADY === 1'b1) begin
            w = 1'b1;
            S_AXI_WVALID <= 1'b0;
         end
      end
      do @(posedge CLK); while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      chk(S_AXI_BRESP, er);
   endtask
   // Bus read into rd
   task automatic rdr(input logic [7:0] a, input logic [1:0] er);
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      rd = S_AXI_RDATA;
      chk(S_AXI_RRESP, er);
   endtask
   // ****************************************
   // Monitor: dead time, discharge, level sweep, LED map
   // ****************************************
   always @(negedge CLK) begin
      if (mon_on) begin
         chk(CATHODE_HALF, GHOST_DISCHARGE);
         if (SCAN_DEAD === 1'b1) begin
            if (p_dead !== 1'b1) begin
               dead_n = 0;
               dis_n = 0;
               win_ok = 1'b1;
            end
            dead_n++;
            dis_n += (GHOST_DISCHARGE === 1'b1);
         end else begin
            chk(GHOST_DISCHARGE, 0);
            if (p_dead === 1'b1 && win_ok) chk(dead_n, 4);
            if (p_dead === 1'b1 && win_ok) chk(dis_n, gh_exp ? 2 : 0);
            if (p_dead === 1'b1 && win_ok) chk(ROW_SCAN_STEP, 2'(p_row + 2'h1));
         end
         if (pat_on && THR_LEVEL !== p_lvl) chk(THR_LEVEL, 3'(p_lvl + 3'h1));
         if (pat_on && THR_LEVEL === p_lvl && MELODY_LED_ON === p_map) chk(LED_ON, bar_exp(p_lvl, grp, p_map));
      end else win_ok = 1'b0;
      p_dead = SCAN_DEAD;
      p_row = ROW_SCAN_STEP;
      p_lvl = THR_LEVEL;
      p_map = MELODY_LED_ON;
   end
   // Hang guard
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {RST_B, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, grp, mon_on, pat_on, gh_exp, win_ok} = '0;
      {bad_count, n_tests, cyc} = '0;
      S_AXI_WSTRB = 4'hf;
      seed = 32'hffc6fad8;
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge CLK);
      rdr(`LBM_GROUP_OFFS, 2'b00);
      chk(rd, `LBM_GROUP_RESET);
      rdr(`LBM_MODE_OFFS, 2'b00);
      chk(rd, `LBM_MODE_RESET);
      rdr(8'h3c, 2'b10);
      chk(rd, 32'h0);
      wr(8'h3c, 32'h1, 2'b10);
      mon_on <= 1'b1;
      repeat (40) @(posedge CLK);
      mon_on <= 1'b0;
      wr(`LBM_MODE_OFFS, 32'h1 << `LBM_MODE_GHOST_BIT, 2'b00);
      gh_exp <= 1'b1;
      mon_on <= 1'b1;
      repeat (40) @(posedge CLK);
      mon_on <= 1'b0;
      wr(`LBM_MODE_OFFS, (32'h1 << `LBM_MODE_GHOST_BIT) | (32'h1 << `LBM_MODE_MUSIC_BIT), 2'b00);
      rdr(`LBM_MODE_OFFS, 2'b00);
      chk(rd, (32'h1 << `LBM_MODE_GHOST_BIT) | (32'h1 << `LBM_MODE_MUSIC_BIT));
      wr(`LBM_THR_OFFS, 32'h14, 2'b00);
      repeat (3) @(posedge CLK);
      chk(AUTO_THR, 0);
      chk(THR_LEVEL, 2);
      rdr(`LBM_STATUS_OFFS, 2'b00);
      chk(rd & 32'h1f, 32'h02);
      wr(`LBM_THR_OFFS, 32'h0, 2'b00);
      repeat (3) @(posedge CLK);
      chk(AUTO_THR, 1);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         pat_on <= 1'b0;
         mon_on <= 1'b0;
         grp = (i < 8) ? cfg[i] : seed[6:0];
         wr(`LBM_GROUP_OFFS, {25'h0, grp}, 2'b00);
         rdr(`LBM_GROUP_OFFS, 2'b00);
         chk(rd, {25'h0, grp});
         repeat (2) @(posedge CLK);
         pat_on <= 1'b1;
         mon_on <= 1'b1;
         repeat (420) @(posedge CLK);
      end
      wrap_up();
   end
endmodule // tb
